// ===== hdl/fwsif_flags.sv
// Interrupt source, summary and live status registers of the fault, wake and supply block
`timescale 1ns/10ps
module fwsif_flags
    import fwsif_pkg::*;
(
    // Clock and battery power-on reset
    input wire logic mclk_i,
    input wire logic rst_n_i,
    // Register port from the serial control interface
    input wire logic [7:0] reg_addr_i,
    input wire logic reg_wr_i,
    input wire logic [7:0] reg_wdata_i,
    output logic [7:0] reg_rdata_o,
    // Live bus fault conditions (bits 7,6,4..0; bit 5 ignored)
    input wire logic [7:0] bus_fault_i,
    // Thermal monitor levels
    input wire logic thermal_recovery_i,
    input wire logic thermal_warning_i,
    // Wake events
    input wire logic local_wake_i,
    input wire logic remote_wake_i,
    // Supply flags: {reg3 good, reg3 uv, reg2 good, reg2 uv, 5V good, 5V uv, batt good, batt uv}
    input wire logic [7:0] supply_flag_i,
    // Interrupt toward the host
    output logic host_irq_n_o
);
    // ------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------
    logic [19:0] sync1;
    logic [19:0] sync2;
    logic [19:0] prev;
    logic [19:0] next_sync1;
    logic [19:0] next_sync2;
    logic [19:0] next_prev;

    always_comb begin
        next_sync1 = {supply_flag_i, local_wake_i, remote_wake_i, thermal_recovery_i,
                      thermal_warning_i, bus_fault_i};
        next_sync2 = sync1;
        next_prev = sync2;
    end

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sync1 <= '0;
            sync2 <= '0;
            prev <= '0;
        end else begin
            sync1 <= next_sync1;
            sync2 <= next_sync2;
            prev <= next_prev;
        end
    end

    logic [7:0] bus_live;
    logic [7:0] supply_live;
    logic [7:0] supply_prev;
    logic th_warn;
    logic th_recv;
    logic th_warn_prev;
    logic th_recv_prev;
    logic lwake;
    logic rwake;
    logic lwake_prev;
    logic rwake_prev;

    assign bus_live = sync2[7:0] & FWSIF_MASK_BUS;
    assign th_warn = sync2[8];
    assign th_recv = sync2[9];
    assign rwake = sync2[10];
    assign lwake = sync2[11];
    assign supply_live = sync2[19:12];
    assign th_warn_prev = prev[8];
    assign th_recv_prev = prev[9];
    assign rwake_prev = prev[10];
    assign lwake_prev = prev[11];
    assign supply_prev = prev[19:12];

    // ------------------------------------------------------------
    // Event capture
    // ------------------------------------------------------------
    logic [7:0] bus_set;
    logic [7:0] wake_set;
    logic [7:0] supply_set;

    always_comb begin
        // Bus faults latch while the fault is present
        bus_set = bus_live;
        wake_set = 8'h00;
        wake_set[FWSIF_BIT_RECOVERY] = th_recv & ~th_recv_prev;
        wake_set[FWSIF_BIT_WARNING] = th_warn & ~th_warn_prev;
        wake_set[FWSIF_BIT_LOCAL_WAKE] = lwake & ~lwake_prev;
        wake_set[FWSIF_BIT_REMOTE_WAKE] = rwake & ~rwake_prev;
        // Supply interrupts fire when a flag becomes set
        supply_set = supply_live & ~supply_prev & FWSIF_MASK_SUPPLY;
    end

    // ------------------------------------------------------------
    // Source registers
    // ------------------------------------------------------------
    logic [7:0] bus_fault_interrupt_source;
    logic [7:0] wake_temp_interrupt_source;
    logic [7:0] supply_interrupt_source;
    logic [7:0] next_bus_src;
    logic [7:0] next_wake_src;
    logic [7:0] next_supply_src;

    always_comb begin
        next_bus_src = bus_fault_interrupt_source;
        next_wake_src = wake_temp_interrupt_source;
        next_supply_src = supply_interrupt_source;
        // Writing zero clears a bit, writing one leaves it
        if (reg_wr_i && reg_addr_i == FWSIF_ADDR_SRC_BUS) begin
            next_bus_src = next_bus_src & reg_wdata_i;
        end else if (reg_wr_i && reg_addr_i == FWSIF_ADDR_SRC_WAKE) begin
            next_wake_src = next_wake_src & reg_wdata_i;
        end else if (reg_wr_i && reg_addr_i == FWSIF_ADDR_SRC_SUPPLY) begin
            next_supply_src = next_supply_src & reg_wdata_i;
        end
        // A new event wins over a clear in the same cycle
        next_bus_src = (next_bus_src | bus_set) & FWSIF_MASK_BUS;
        next_wake_src = (next_wake_src | wake_set) & FWSIF_MASK_WAKE;
        next_supply_src = (next_supply_src | supply_set) & FWSIF_MASK_SUPPLY;
    end

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            bus_fault_interrupt_source <= FWSIF_RESET_VALUE;
            wake_temp_interrupt_source <= FWSIF_RESET_VALUE;
            supply_interrupt_source <= FWSIF_RESET_VALUE;
        end else begin
            bus_fault_interrupt_source <= next_bus_src;
            wake_temp_interrupt_source <= next_wake_src;
            supply_interrupt_source <= next_supply_src;
        end
    end

    // ------------------------------------------------------------
    // Summary, live status and read data
    // ------------------------------------------------------------
    logic [7:0] summary;
    logic [7:0] thermal_live_status;
    logic [7:0] bus_fault_live_status;
    logic [7:0] next_rdata;
    logic next_irq_n;

    always_comb begin
        summary = 8'h00;
        summary[FWSIF_SUM_BUS] = |bus_fault_interrupt_source;
        summary[FWSIF_SUM_WAKE] = |wake_temp_interrupt_source;
        summary[FWSIF_SUM_SUPPLY] = |supply_interrupt_source;
        thermal_live_status = 8'h00;
        thermal_live_status[FWSIF_TH_RECOVERY] = th_recv;
        thermal_live_status[FWSIF_TH_WARNING] = th_warn;
        bus_fault_live_status = bus_live;
        next_irq_n = ~(|summary);
    end

    always_comb begin
        if (reg_addr_i == FWSIF_ADDR_SUMMARY) begin
            next_rdata = summary;
        end else if (reg_addr_i == FWSIF_ADDR_SRC_BUS) begin
            next_rdata = bus_fault_interrupt_source;
        end else if (reg_addr_i == FWSIF_ADDR_SRC_WAKE) begin
            next_rdata = wake_temp_interrupt_source;
        end else if (reg_addr_i == FWSIF_ADDR_SRC_SUPPLY) begin
            next_rdata = supply_interrupt_source;
        end else if (reg_addr_i == FWSIF_ADDR_BUS_STATUS) begin
            next_rdata = bus_fault_live_status;
        end else if (reg_addr_i == FWSIF_ADDR_THERMAL) begin
            next_rdata = thermal_live_status;
        end else if (reg_addr_i == FWSIF_ADDR_SUPPLY_STATUS) begin
            // Supply status follows; its top bit is regulator 3 good
            next_rdata = supply_live;
        end else begin
            next_rdata = 8'h00;
        end
    end

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            reg_rdata_o <= FWSIF_RESET_VALUE;
            host_irq_n_o <= 1'b1;
        end else begin
            reg_rdata_o <= next_rdata;
            host_irq_n_o <= next_irq_n;
        end
    end
endmodule : fwsif_flags

// ===== hdl/fwsif_pkg.sv
// Package of offsets, field positions and reset values for the fault, wake and supply flags
//------------------------------------------------------------
// Notes on behaviour
// - Bus dominant timeout sets source1 bit 7.
// - Data pins short sets source1 bit 6.
// - Transmit stuck dominant sets bit 4; bit 5 reserved.
// - CANL to supply bit 3, ground bit 2.
// - CANH to ground bit 1, supply bit 0.
// - Temperature recovery sets source2 bit 3; upper reserved.
// - Temperature warning sets source2 bit 2.
// - Local wake pin event sets source2 bit 1.
// - Remote bus wake sets source2 bit 0.
// - Regulator 3 good bit 7, undervoltage bit 6.
// - Regulator 2 good bit 5, undervoltage bit 4.
// - Five volt good bit 3, undervoltage bit 2.
// - Battery good bit 1, undervoltage bit 0.
// - Live bus faults readable at same positions.
// - Recovery 140 status in thermal bit 1.
// - Warning 160 status in thermal bit 0.
// - Summary bits flag pending source registers.
//------------------------------------------------------------
package fwsif_pkg;
    localparam logic [7:0] FWSIF_ADDR_SUMMARY = 8'h07;
    localparam logic [7:0] FWSIF_ADDR_SRC_BUS = 8'h08;
    localparam logic [7:0] FWSIF_ADDR_SRC_WAKE = 8'h09;
    localparam logic [7:0] FWSIF_ADDR_SRC_SUPPLY = 8'h0a;
    localparam logic [7:0] FWSIF_ADDR_RESERVED = 8'h0b;
    localparam logic [7:0] FWSIF_ADDR_BUS_STATUS = 8'h0c;
    localparam logic [7:0] FWSIF_ADDR_THERMAL = 8'h0d;
    localparam logic [7:0] FWSIF_ADDR_SUPPLY_STATUS = 8'h0e;
    localparam logic [7:0] FWSIF_RESET_VALUE = 8'h00;
    // Implemented bits: bus source omits bit 5, wake source bits 3..0
    localparam logic [7:0] FWSIF_MASK_BUS = 8'hdf;
    localparam logic [7:0] FWSIF_MASK_WAKE = 8'h0f;
    localparam logic [7:0] FWSIF_MASK_SUPPLY = 8'hff;
    localparam logic [7:0] FWSIF_MASK_THERMAL = 8'h03;
    localparam int FWSIF_BIT_RECOVERY = 3;
    localparam int FWSIF_BIT_WARNING = 2;
    localparam int FWSIF_BIT_LOCAL_WAKE = 1;
    localparam int FWSIF_BIT_REMOTE_WAKE = 0;
    localparam int FWSIF_TH_RECOVERY = 1;
    localparam int FWSIF_TH_WARNING = 0;
    localparam int FWSIF_SUM_BUS = 0;
    localparam int FWSIF_SUM_WAKE = 1;
    localparam int FWSIF_SUM_SUPPLY = 2;
endpackage : fwsif_pkg

// ===== verif/fwsif_chk.sv
// Checker of read data, flag latching and interrupt timing
`timescale 1ns/10ps
module fwsif_chk (
    // Watched ports
    input wire logic mclk_i,
    input wire logic rst_n_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic reg_wr_i,
    input wire logic [7:0] reg_rdata_o,
    input wire logic [7:0] bus_fault_i,
    input wire logic [7:0] supply_flag_i,
    input wire logic host_irq_n_o
);
    default clocking @(posedge mclk_i);
    endclocking
    default disable iff (!rst_n_i);
    sequence s_live(a);
        (reg_addr_i == a && $stable(bus_fault_i))[*6];
    endsequence
    property p_live;
        s_live(8'h0c) |-> reg_rdata_o == (bus_fault_i & 8'hdf);
    endproperty
    a_live: assert property (p_live) else $error("live status wrong");
    property p_brsv;
        $past(reg_addr_i) == 8'h08 |-> !reg_rdata_o[5];
    endproperty
    a_brsv: assert property (p_brsv) else $error("bus bit 5 set");
    property p_wrsv;
        $past(reg_addr_i) == 8'h09 |-> reg_rdata_o[7:4] == 4'h0;
    endproperty
    a_wrsv: assert property (p_wrsv) else $error("wake upper bits set");
    property p_srsv;
        $past(reg_addr_i) == 8'h07 |-> reg_rdata_o[7:3] == 5'h00;
    endproperty
    a_srsv: assert property (p_srsv) else $error("summary upper bits set");
    property p_irq;
        $past(reg_addr_i) == 8'h07 |-> host_irq_n_o == (reg_rdata_o[2:0] == 3'h0);
    endproperty
    a_irq: assert property (p_irq) else $error("irq disagrees with summary");
    property p_hold;
        !host_irq_n_o && !$past(reg_wr_i) |=> !host_irq_n_o;
    endproperty
    a_hold: assert property (p_hold) else $error("flag dropped unasked");
    property p_sup;
        $rose(supply_flag_i[0]) |-> ##[1:6] !host_irq_n_o;
    endproperty
    a_sup: assert property (p_sup) else $error("no supply irq");
    property p_dom;
        bus_fault_i[7] [*3] |-> ##[1:5] !host_irq_n_o;
    endproperty
    a_dom: assert property (p_dom) else $error("no dominant irq");
endmodule : fwsif_chk
bind fwsif_flags fwsif_chk i_chk (
    .mclk_i(mclk_i), .rst_n_i(rst_n_i), .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i),
    .reg_rdata_o(reg_rdata_o), .bus_fault_i(bus_fault_i), .supply_flag_i(supply_flag_i),
    .host_irq_n_o(host_irq_n_o)
);

// ===== verif/fwsif_host.sv
// Host model that reads, writes and clears the flag registers
`timescale 1ns/10ps
module fwsif_host (
    // Clock
    input wire logic mclk_i,
    // Register port
    output logic [7:0] reg_addr_o = 8'h00,
    output logic reg_wr_o = 1'b0,
    output logic [7:0] reg_wdata_o = 8'h00,
    input wire logic [7:0] reg_rdata_i
);
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk_i);
        reg_addr_o <= a;
        reg_wdata_o <= d;
        reg_wr_o <= 1'b1;
        @(posedge mclk_i);
        reg_wr_o <= 1'b0;
        reg_wdata_o <= ~d;
    endtask : wr
    // Read data is registered, so it is taken two edges after the address
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge mclk_i);
        reg_addr_o <= a;
        repeat (2) @(posedge mclk_i);
        d = reg_rdata_i;
    endtask : rd
    task automatic clr(input logic [7:0] a, output logic [7:0] d);
        rd(a, d);
        wr(a, 8'h00);
    endtask : clr
endmodule : fwsif_host

// ===== verif/tb_top.sv
// Top testbench of the fault, wake and supply flag block
`timescale 1ns/10ps
module tb_top
    import fwsif_pkg::*;
;
    logic mclk_i, rst_n_i, reg_wr_i, host_irq_n_o;
    logic [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o, bus_fault_i, supply_flag_i, got;
    logic [3:0] wake_temp;
    int n_mismatch = 0, check_count = 0, cycles = 0, seed = 35;
    fwsif_flags i_dut (
        .mclk_i(mclk_i), .rst_n_i(rst_n_i), .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i),
        .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o), .bus_fault_i(bus_fault_i),
        .thermal_recovery_i(wake_temp[3]), .thermal_warning_i(wake_temp[2]),
        .local_wake_i(wake_temp[1]), .remote_wake_i(wake_temp[0]),
        .supply_flag_i(supply_flag_i), .host_irq_n_o(host_irq_n_o));
    fwsif_host i_host (.mclk_i(mclk_i), .reg_addr_o(reg_addr_i), .reg_wr_o(reg_wr_i),
        .reg_wdata_o(reg_wdata_i), .reg_rdata_i(reg_rdata_o));
    function automatic logic [7:0] bit_exp(input int i, input logic [7:0] mask);
        return (8'h01 << i) & mask;
    endfunction : bit_exp
    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        check_count++;
        if (g !== e) begin
            n_mismatch++;
            $display("unexpected at %0t: got %h expected %h", $time, g, e);
        end
    endtask : chk
    task automatic wrap_up;
        if (n_mismatch == 0 && check_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : wrap_up
    initial begin
        mclk_i = 1'b0;
        forever #5 mclk_i = ~mclk_i;
    end
    always @(posedge mclk_i) begin
        cycles++;
        if (cycles == 20000) begin
            n_mismatch++;
            wrap_up();
        end
    end
    initial begin
        {rst_n_i, bus_fault_i, supply_flag_i, wake_temp} = '0;
        repeat (8) @(posedge mclk_i);
        rst_n_i <= 1'b1;
        for (int a = 7; a <= 13; a++) begin
            i_host.rd(8'(a), got);
            chk(got, FWSIF_RESET_VALUE);
        end
        // One bus, one supply and (in the first four steps only) one wake event at a time, then latched flags are read and cleared
        for (int i = 0; i < 8; i++) begin
            bus_fault_i <= 8'h01 << i;
            supply_flag_i <= 8'h01 << i;
            wake_temp <= 4'(8'h01 << i);
            repeat (5) @(posedge mclk_i);
            i_host.rd(FWSIF_ADDR_BUS_STATUS, got);
            chk(got, bit_exp(i, FWSIF_MASK_BUS));
            i_host.rd(FWSIF_ADDR_THERMAL, got);
            chk(got, bit_exp(i, 8'h0c) >> 2);
            i_host.rd(FWSIF_ADDR_SUPPLY_STATUS, got);
            chk(got, bit_exp(i, 8'hff));
            {bus_fault_i, supply_flag_i, wake_temp} <= '0;
            i_host.rd(FWSIF_ADDR_SUMMARY, got);
            chk(got, {5'h00, 1'b1, i < 4, i != 5});
            i_host.clr(FWSIF_ADDR_SRC_BUS, got);
            chk(got, bit_exp(i, FWSIF_MASK_BUS));
            i_host.clr(FWSIF_ADDR_SRC_WAKE, got);
            chk(got, bit_exp(i, FWSIF_MASK_WAKE));
            i_host.clr(FWSIF_ADDR_SRC_SUPPLY, got);
            chk(got, bit_exp(i, FWSIF_MASK_SUPPLY));
            repeat (2) @(posedge mclk_i);
            chk({7'h00, host_irq_n_o}, 8'h01);
        end
        for (int k = 0; k < 100; k++) begin
            bus_fault_i <= 8'($random(seed));
            supply_flag_i <= 8'($random(seed));
            wake_temp <= 4'($random(seed));
            i_host.wr(FWSIF_ADDR_SUMMARY + 8'(k % 7), 8'($random(seed)));
            i_host.rd(FWSIF_ADDR_SUMMARY + 8'(k % 7), got);
            if (k % 7 == 5) begin
                chk(got, bus_fault_i & FWSIF_MASK_BUS);
            end
            if (k % 7 == 6) begin
                chk(got, {6'h00, wake_temp[3], wake_temp[2]});
            end
        end
        {bus_fault_i, supply_flag_i, wake_temp} <= '0;
        i_host.wr(FWSIF_ADDR_RESERVED, 8'hff);
        for (int a = 8; a <= 10; a++) begin
            i_host.clr(8'(a), got);
        end
        i_host.rd(FWSIF_ADDR_RESERVED, got);
        chk(got, 8'h00);
        i_host.rd(FWSIF_ADDR_SUMMARY, got);
        chk(got, 8'h00);
        chk({7'h00, host_irq_n_o}, 8'h01);
        wrap_up();
    end
endmodule : tb_top
